// file: cfisoe_pkg.sv
/*
  Constants and types shared by the clock fanout select and enable logic:
  output count, pin bundle layout for the synchroniser, edge count for the
  enable handshake, source codes and the one-hot output state machine.
  Assumes it is compiled before every other file of the block.
*/
package cfisoe_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_OUTPUTS = 10;
  localparam int unsigned SYNC_W      = 8;

  // ----------------------------------------------------------------------
  // bit positions inside the synchronised pin bundle
  // ----------------------------------------------------------------------
  localparam int unsigned PIN_SEL_LOW  = 0;
  localparam int unsigned PIN_SEL_HIGH = 1;
  localparam int unsigned PIN_OE       = 2;
  localparam int unsigned PIN_A        = 3;
  localparam int unsigned PIN_A_COMP   = 4;
  localparam int unsigned PIN_B        = 5;
  localparam int unsigned PIN_B_COMP   = 6;
  localparam int unsigned PIN_OSC      = 7;

  // ----------------------------------------------------------------------
  // enable handshake: transitions land on this falling edge of the input
  // ----------------------------------------------------------------------
  localparam logic [1:0] EDGE_COUNT   = 2'h2;
  localparam logic [1:0] EDGE_CNT_RST = 2'h0;
  localparam logic [1:0] EDGE_CNT_ONE = 2'h1;

  // ----------------------------------------------------------------------
  // source codes, upper select bit first
  // ----------------------------------------------------------------------
  localparam logic [1:0] SRC_DIFF_A = 2'h0;
  localparam logic [1:0] SRC_DIFF_B = 2'h1;

  // ----------------------------------------------------------------------
  // reset values of the fanout outputs and synchroniser, and the all-ones fanout word
  // ----------------------------------------------------------------------
  localparam logic [NUM_OUTPUTS-1:0] FANOUT_RST    = 10'h000;
  localparam logic [NUM_OUTPUTS-1:0] FANOUT_OE_RST = 10'h3ff;
  localparam logic [NUM_OUTPUTS-1:0] FANOUT_ALL    = 10'h3ff;
  localparam logic [SYNC_W-1:0]      SYNC_RST      = 8'h00;

  // ----------------------------------------------------------------------
  // output state machine
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    OUT_HIZ      = 5'h01,  // disabled, high impedance
    OUT_WEAK_LOW = 5'h02,  // enable seen, weak pull-down, counting falls
    OUT_BUFFER   = 5'h04,  // buffering the selected clock
    OUT_BUF_OFF  = 5'h08,  // disable seen, still buffering, counting falls
    OUT_LOW      = 5'h10   // driven low, waiting for a rising edge
  } cfisoe_state_e;

endpackage

// file: cfisoe_src_model.sv
/*
  Far-side model: the two differential clock sources and the oscillator
  input source of the clock fanout block.
  Assumes the bench's clock; every level changes just after a rising edge.
*/
`timescale 1ns/1ps

module cfisoe_src_model (
  input  wire logic       clk,   // bench clock
  input  wire logic [2:0] run,   // toggle enables {osc, b, a}
  input  wire logic [3:0] half,  // half period in clk cycles
  input  wire logic [4:0] still, // static levels {osc, b, bc, a, ac}
  output logic            a,     // pair a true pin
  output logic            ac,    // pair a complement
  output logic            b,     // pair b true pin
  output logic            bc,    // pair b complement
  output logic            osc    // oscillator input
);
  logic [3:0] cnt_reg = 4'h0;
  logic       ph_reg  = 1'b0;
  logic [4:0] lvl_reg = 5'h00;

  // one shared phase; a stopped source holds its static level
  always @(posedge clk) begin
    if (cnt_reg + 4'h1 >= half) begin
      cnt_reg <= 4'h0;
      ph_reg  <= ~ph_reg;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
    lvl_reg[1:0] <= run[0] ? {ph_reg, ~ph_reg} : still[1:0];
    lvl_reg[3:2] <= run[1] ? {ph_reg, ~ph_reg} : still[3:2];
    lvl_reg[4]   <= run[2] ? ph_reg : still[4];
  end

  // osc is always driven, never left floating in crystal mode
  assign {osc, b, bc, a, ac} = lvl_reg;
endmodule

// file: cfisoe_sync.sv
/*
  Two-stage synchroniser for the bundle of asynchronous pins of the clock
  fanout block. Assumes every bit is sampled independently; a bundle word
  is not coherent across bits during a change.
*/
`timescale 1ns/1ps

module cfisoe_sync (
  input  wire logic                        clk,      // sampling clock
  input  wire logic                        rst_n,    // synchronous, active low
  input  wire logic [cfisoe_pkg::SYNC_W-1:0] async_in, // raw pins
  output logic      [cfisoe_pkg::SYNC_W-1:0] sync_out  // two flops later
);

  logic [cfisoe_pkg::SYNC_W-1:0] meta_reg;
  logic [cfisoe_pkg::SYNC_W-1:0] sync_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= cfisoe_pkg::SYNC_RST;
      sync_reg <= cfisoe_pkg::SYNC_RST;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// file: cfisoe_top.sv
/*
  Pin-programmed clock fanout: source selection among two differential
  inputs and a crystal oscillator input, fanout to ten single-ended outputs,
  and an output enable that is resynchronised to the selected input clock.
  Assumes CLK oversamples every input clock well above its rate; the input
  clocks are seen as sampled levels, and each output is modelled as a
  value, an active-low drive enable and a weak pull-down flag.
*/
`timescale 1ns/1ps

module cfisoe_top (
  input  wire logic                               CLK,                   // 200 MHz core clock
  input  wire logic                               RST_N,                 // sync reset, active low
  input  wire logic                               SOURCE_SELECT_LOW,     // select pin, low bit
  input  wire logic                               SOURCE_SELECT_HIGH,    // select pin, high bit
  input  wire logic                               OUTPUT_ENABLE,         // enable pin
  input  wire logic                               DIFF_INPUT_A,          // pair a, true pin
  input  wire logic                               DIFF_INPUT_A_COMPLEMENT, // pair a, complement
  input  wire logic                               DIFF_INPUT_B,          // pair b, true pin
  input  wire logic                               DIFF_INPUT_B_COMPLEMENT, // pair b, complement
  input  wire logic                               OSCILLATOR_INPUT,      // crystal or clock in
  output logic                                    OSCILLATOR_DRIVE_PIN,  // crystal amp output
  output logic                                    XTAL_POWER_ON,         // crystal amp powered
  output logic [cfisoe_pkg::NUM_OUTPUTS-1:0]      FANOUT_OUTPUT,         // output levels
  output logic [cfisoe_pkg::NUM_OUTPUTS-1:0]      FANOUT_OUTPUT_OE_N,    // low while driven
  output logic [cfisoe_pkg::NUM_OUTPUTS-1:0]      FANOUT_WEAK_PULLDOWN   // weak pull-down on
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // open pins read low, so a floating pair gives a low output
  function automatic logic pair_level(input logic true_pin, input logic comp_pin);
    return true_pin & ~comp_pin;
  endfunction

  // one more counted fall; the wait ends at two, so the count never wraps
  function automatic logic [1:0] count_fall(input logic [1:0] cnt);
    return cnt + cfisoe_pkg::EDGE_CNT_ONE;
  endfunction

  // states in which every output carries the selected clock
  function automatic logic is_buffering(input cfisoe_pkg::cfisoe_state_e st);
    return (st == cfisoe_pkg::OUT_BUFFER) || (st == cfisoe_pkg::OUT_BUF_OFF);
  endfunction

  // states in which the output stage drives the pin hard
  function automatic logic is_driving(input cfisoe_pkg::cfisoe_state_e st);
    return is_buffering(st) || (st == cfisoe_pkg::OUT_LOW);
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  logic [cfisoe_pkg::SYNC_W-1:0] pins_raw;
  logic [cfisoe_pkg::SYNC_W-1:0] pins_sync;

  // open inputs are taken to read low, matching the open rows of the pair table
  assign pins_raw[cfisoe_pkg::PIN_SEL_LOW]  = SOURCE_SELECT_LOW;
  assign pins_raw[cfisoe_pkg::PIN_SEL_HIGH] = SOURCE_SELECT_HIGH;
  assign pins_raw[cfisoe_pkg::PIN_OE]       = OUTPUT_ENABLE;
  assign pins_raw[cfisoe_pkg::PIN_A]        = DIFF_INPUT_A;
  assign pins_raw[cfisoe_pkg::PIN_A_COMP]   = DIFF_INPUT_A_COMPLEMENT;
  assign pins_raw[cfisoe_pkg::PIN_B]        = DIFF_INPUT_B;
  assign pins_raw[cfisoe_pkg::PIN_B_COMP]   = DIFF_INPUT_B_COMPLEMENT;
  assign pins_raw[cfisoe_pkg::PIN_OSC]      = OSCILLATOR_INPUT;

  cfisoe_sync u_sync (
    .clk      (CLK),
    .rst_n    (RST_N),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  logic       sel_low;
  logic       sel_high;
  logic       oe_pin;
  logic       crystal_mode;
  logic [1:0] src_code;
  logic       diff_a_level;
  logic       diff_b_level;
  logic       osc_level;
  logic       sel_clk;

  assign sel_low      = pins_sync[cfisoe_pkg::PIN_SEL_LOW];
  assign sel_high     = pins_sync[cfisoe_pkg::PIN_SEL_HIGH];
  assign oe_pin       = pins_sync[cfisoe_pkg::PIN_OE];
  assign crystal_mode = sel_high;
  assign src_code     = {sel_high, sel_low};

  // a pair reads high only with true high and complement low
  assign diff_a_level = pair_level(pins_sync[cfisoe_pkg::PIN_A],
                                   pins_sync[cfisoe_pkg::PIN_A_COMP]);
  assign diff_b_level = pair_level(pins_sync[cfisoe_pkg::PIN_B],
                                   pins_sync[cfisoe_pkg::PIN_B_COMP]);

  // the crystal amplifier inverts, so a static oscillator level comes out flipped
  assign osc_level = ~pins_sync[cfisoe_pkg::PIN_OSC];

  // lower select is a don't-care once the upper one is set
  assign sel_clk = crystal_mode                        ? osc_level :
                   (src_code == cfisoe_pkg::SRC_DIFF_B) ? diff_b_level :
                                                          diff_a_level;

  // ----------------------------------------------------------------------
  // edge detection on the selected clock
  // ----------------------------------------------------------------------
  logic sel_clk_prev_reg;
  logic fall_edge;
  logic rise_edge;

  // a select change can fake one edge; the handshake tolerates that
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sel_clk_prev_reg <= 1'b0;
    end else begin
      sel_clk_prev_reg <= sel_clk;
    end
  end

  assign fall_edge = sel_clk_prev_reg & ~sel_clk;
  assign rise_edge = ~sel_clk_prev_reg & sel_clk;

  // ----------------------------------------------------------------------
  // output enable state machine
  // ----------------------------------------------------------------------
  cfisoe_pkg::cfisoe_state_e state_reg;
  cfisoe_pkg::cfisoe_state_e state_next;
  logic [1:0]                fall_cnt_reg;
  logic [1:0]                fall_cnt_next;
  logic                      last_fall;

  // the wait ends on the counted fall itself, not a cycle later
  assign last_fall = fall_edge && (count_fall(fall_cnt_reg) == cfisoe_pkg::EDGE_COUNT);

  // drive starts and stops only on input edges, which keeps pulses whole
  always_comb begin
    state_next    = state_reg;
    fall_cnt_next = fall_cnt_reg;
    case (state_reg)
      cfisoe_pkg::OUT_HIZ: begin
        fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        if (oe_pin) begin
          state_next = cfisoe_pkg::OUT_WEAK_LOW;
        end
      end
      cfisoe_pkg::OUT_WEAK_LOW: begin
        if (!oe_pin) begin
          state_next    = cfisoe_pkg::OUT_HIZ;
          fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        end else if (last_fall) begin
          state_next    = cfisoe_pkg::OUT_BUFFER;
          fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        end else if (fall_edge) begin
          fall_cnt_next = count_fall(fall_cnt_reg);
        end
      end
      cfisoe_pkg::OUT_BUFFER: begin
        fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        if (!oe_pin) begin
          state_next = cfisoe_pkg::OUT_BUF_OFF;
        end
      end
      cfisoe_pkg::OUT_BUF_OFF: begin
        if (oe_pin) begin
          state_next    = cfisoe_pkg::OUT_BUFFER;
          fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        end else if (last_fall) begin
          state_next    = cfisoe_pkg::OUT_LOW;
          fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        end else if (fall_edge) begin
          fall_cnt_next = count_fall(fall_cnt_reg);
        end
      end
      cfisoe_pkg::OUT_LOW: begin
        fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
        if (rise_edge) begin
          state_next = cfisoe_pkg::OUT_HIZ;
        end
      end
      default: begin
        state_next    = cfisoe_pkg::OUT_HIZ;
        fall_cnt_next = cfisoe_pkg::EDGE_CNT_RST;
      end
    endcase
  end

  // state and fall counter, counted on the selected input only
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg    <= cfisoe_pkg::OUT_HIZ;
      fall_cnt_reg <= cfisoe_pkg::EDGE_CNT_RST;
    end else begin
      state_reg    <= state_next;
      fall_cnt_reg <= fall_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // output drive decode
  // ----------------------------------------------------------------------
  logic                               buffering;
  logic                               driving;
  logic                               weak_on;
  logic                               out_level;
  logic [cfisoe_pkg::NUM_OUTPUTS-1:0] fanout_next;
  logic [cfisoe_pkg::NUM_OUTPUTS-1:0] fanout_oe_n_next;
  logic [cfisoe_pkg::NUM_OUTPUTS-1:0] fanout_weak_next;

  // a stopped input just freezes the buffered level, so nothing oscillates
  assign buffering = is_buffering(state_next);
  assign driving   = is_driving(state_next);
  assign weak_on   = (state_next == cfisoe_pkg::OUT_WEAK_LOW);
  assign out_level = buffering & sel_clk;

  // every output takes the same value; replication keeps skew at zero
  assign fanout_next      = out_level ? cfisoe_pkg::FANOUT_ALL
                                      : cfisoe_pkg::FANOUT_RST;
  assign fanout_oe_n_next = driving   ? cfisoe_pkg::FANOUT_RST
                                      : cfisoe_pkg::FANOUT_ALL;
  assign fanout_weak_next = weak_on   ? cfisoe_pkg::FANOUT_ALL
                                      : cfisoe_pkg::FANOUT_RST;

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  logic [cfisoe_pkg::NUM_OUTPUTS-1:0] fanout_reg;
  logic [cfisoe_pkg::NUM_OUTPUTS-1:0] fanout_oe_n_reg;
  logic [cfisoe_pkg::NUM_OUTPUTS-1:0] fanout_weak_reg;
  logic                               xtal_on_reg;
  logic                               osc_drive_reg;

  // levels registered from the next state so they line up with the edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fanout_reg <= cfisoe_pkg::FANOUT_RST;
    end else begin
      fanout_reg <= fanout_next;
    end
  end

  // drive enable starts high so nothing is driven until enable is seen
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fanout_oe_n_reg <= cfisoe_pkg::FANOUT_OE_RST;
    end else begin
      fanout_oe_n_reg <= fanout_oe_n_next;
    end
  end

  // weak pull-down flag, only set during the enable wait
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fanout_weak_reg <= cfisoe_pkg::FANOUT_RST;
    end else begin
      fanout_weak_reg <= fanout_weak_next;
    end
  end

  // ----------------------------------------------------------------------
  // crystal amplifier
  // ----------------------------------------------------------------------
  // amplifier power follows the upper select; off during reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      xtal_on_reg <= 1'b0;
    end else begin
      xtal_on_reg <= crystal_mode;
    end
  end

  // inverting drive, idle low when off so an unpowered crystal is not pushed
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      osc_drive_reg <= 1'b0;
    end else begin
      osc_drive_reg <= crystal_mode & osc_level;
    end
  end

  assign FANOUT_OUTPUT        = fanout_reg;
  assign FANOUT_OUTPUT_OE_N   = fanout_oe_n_reg;
  assign FANOUT_WEAK_PULLDOWN = fanout_weak_reg;
  assign XTAL_POWER_ON        = xtal_on_reg;
  assign OSCILLATOR_DRIVE_PIN = osc_drive_reg;

endmodule

// file: cfisoe_top_monitor.sv
/*
  Concurrent checks on the pins of the clock fanout block.
  Assumes the bind below; a pin change reaches the outputs three edges later.
*/
`timescale 1ns/1ps

module cfisoe_monitor (
  input wire logic       CLK,                     // core clock
  input wire logic       RST_N,                   // sync reset, active low
  input wire logic       SOURCE_SELECT_LOW,       // select low bit
  input wire logic       SOURCE_SELECT_HIGH,      // select high bit
  input wire logic       OUTPUT_ENABLE,           // enable pin
  input wire logic       DIFF_INPUT_A,            // pair a true
  input wire logic       DIFF_INPUT_A_COMPLEMENT, // pair a complement
  input wire logic       DIFF_INPUT_B,            // pair b true
  input wire logic       DIFF_INPUT_B_COMPLEMENT, // pair b complement
  input wire logic       OSCILLATOR_INPUT,        // oscillator input
  input wire logic       OSCILLATOR_DRIVE_PIN,    // crystal amp output
  input wire logic       XTAL_POWER_ON,           // crystal amp powered
  input wire logic [9:0] FANOUT_OUTPUT,           // output levels
  input wire logic [9:0] FANOUT_OUTPUT_OE_N,      // low while driven
  input wire logic [9:0] FANOUT_WEAK_PULLDOWN     // weak pull-down on
);
  logic [6:0] p1_reg, p2_reg, p3_reg;
  logic [2:0] up_reg;
  wire        ready = up_reg == 3'h4;
  // selected level as the design sees it, three edges back
  wire        sel_lvl = p3_reg[6] ? ~p3_reg[4] :
                        p3_reg[5] ? (p3_reg[2] & ~p3_reg[3]) : (p3_reg[0] & ~p3_reg[1]);

  // pin history; checks wait four edges after reset so it is filled
  always_ff @(posedge CLK) begin
    p1_reg <= {SOURCE_SELECT_HIGH, SOURCE_SELECT_LOW, OSCILLATOR_INPUT, DIFF_INPUT_B_COMPLEMENT,
               DIFF_INPUT_B, DIFF_INPUT_A_COMPLEMENT, DIFF_INPUT_A};
    p2_reg <= p1_reg;
    p3_reg <= p2_reg;
    up_reg <= !RST_N ? 3'h0 : (ready ? up_reg : up_reg + 3'h1);
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_XTAL: assert property (ready |-> XTAL_POWER_ON == p3_reg[6])
    else $error("crystal power does not follow the select");
  AST_OSC_DRV: assert property (ready |-> OSCILLATOR_DRIVE_PIN == (p3_reg[6] & ~p3_reg[4]))
    else $error("oscillator drive level wrong");
  AST_SAME: assert property ((FANOUT_OUTPUT == 10'h000 || FANOUT_OUTPUT == 10'h3ff)
    && (FANOUT_OUTPUT_OE_N == 10'h000 || FANOUT_OUTPUT_OE_N == 10'h3ff))
    else $error("outputs differ from each other");
  AST_WEAK_HIZ: assert property (|FANOUT_WEAK_PULLDOWN |-> &FANOUT_OUTPUT_OE_N)
    else $error("weak pull-down while driven");
  AST_WEAK_OFF: assert property (ready && FANOUT_WEAK_PULLDOWN[0] && !$past(OUTPUT_ENABLE, 2)
    |=> !FANOUT_WEAK_PULLDOWN[0])
    else $error("enable wait not dropped on disable");
  AST_WEAK_ON: assert property (ready && &FANOUT_OUTPUT_OE_N && !FANOUT_WEAK_PULLDOWN[0]
    && $past(OUTPUT_ENABLE, 2) |=> &FANOUT_WEAK_PULLDOWN)
    else $error("enable did not start the weak wait");
  AST_FOLLOW: assert property (ready && !FANOUT_OUTPUT_OE_N[0] ##1 !FANOUT_OUTPUT_OE_N[0]
    |-> FANOUT_OUTPUT[0] == sel_lvl)
    else $error("driven output does not follow selected input");
  AST_HIZ_LOW: assert property (ready && $rose(FANOUT_OUTPUT_OE_N[0])
    |-> $past(FANOUT_OUTPUT[0]) == 1'b0 && !FANOUT_WEAK_PULLDOWN[0])
    else $error("high impedance not entered from low");
  AST_EN_WAIT: assert property (ready && $fell(FANOUT_OUTPUT_OE_N[0])
    |-> $past(FANOUT_WEAK_PULLDOWN[0]) && FANOUT_OUTPUT[0] == 1'b0)
    else $error("drive began without the enable wait");
endmodule

bind cfisoe_top cfisoe_monitor i_cfisoe_monitor (.CLK(CLK), .RST_N(RST_N),
  .SOURCE_SELECT_LOW(SOURCE_SELECT_LOW), .SOURCE_SELECT_HIGH(SOURCE_SELECT_HIGH),
  .OUTPUT_ENABLE(OUTPUT_ENABLE), .DIFF_INPUT_A(DIFF_INPUT_A),
  .DIFF_INPUT_A_COMPLEMENT(DIFF_INPUT_A_COMPLEMENT), .DIFF_INPUT_B(DIFF_INPUT_B),
  .DIFF_INPUT_B_COMPLEMENT(DIFF_INPUT_B_COMPLEMENT), .OSCILLATOR_INPUT(OSCILLATOR_INPUT),
  .OSCILLATOR_DRIVE_PIN(OSCILLATOR_DRIVE_PIN), .XTAL_POWER_ON(XTAL_POWER_ON),
  .FANOUT_OUTPUT(FANOUT_OUTPUT), .FANOUT_OUTPUT_OE_N(FANOUT_OUTPUT_OE_N),
  .FANOUT_WEAK_PULLDOWN(FANOUT_WEAK_PULLDOWN));

// file: testbench.sv
/*
  Self-checking bench for the clock fanout block with a reference model.
  Assumes the source model and the checker are compiled before it.
*/
`timescale 1ns/1ps

module testbench;
  logic       CLK = 1'b0, RST_N = 1'b0, armed = 1'b0;
  logic       sel_lo = 1'b0, sel_hi = 1'b0, oe = 1'b0;
  logic [2:0] run = 3'h7;
  logic [3:0] half = 4'h2;
  logic [4:0] still = 5'h00;
  logic       a, ac, b, bc, osc, xtal, drv, cur, m_prev;
  logic [9:0] fo, fo_oen, fo_weak;
  logic [7:0] m_s1, m_s2;
  logic       m_out, m_oen, m_weak, m_xtal, m_drv;
  int         m_st, m_cnt, nst, ncnt, err_total = 0, total_checks = 0;
  wire  [7:0] pins = {osc, bc, b, ac, a, oe, sel_hi, sel_lo};

  initial forever #2.5 CLK = ~CLK;

  cfisoe_src_model i_cfisoe_src_model (.clk(CLK), .run(run), .half(half), .still(still),
    .a(a), .ac(ac), .b(b), .bc(bc), .osc(osc));
  cfisoe_top i_cfisoe_top (.CLK(CLK), .RST_N(RST_N), .SOURCE_SELECT_LOW(sel_lo),
    .SOURCE_SELECT_HIGH(sel_hi), .OUTPUT_ENABLE(oe), .DIFF_INPUT_A(a),
    .DIFF_INPUT_A_COMPLEMENT(ac), .DIFF_INPUT_B(b), .DIFF_INPUT_B_COMPLEMENT(bc),
    .OSCILLATOR_INPUT(osc), .OSCILLATOR_DRIVE_PIN(drv), .XTAL_POWER_ON(xtal),
    .FANOUT_OUTPUT(fo), .FANOUT_OUTPUT_OE_N(fo_oen), .FANOUT_WEAK_PULLDOWN(fo_weak));

  // selected level: oscillator inverted, pair high only for true high, complement low
  function automatic logic selc(input logic [7:0] s);
    return s[1] ? ~s[7] : s[0] ? (s[5] & ~s[6]) : (s[3] & ~s[4]);
  endfunction

  // model states: 0 hi-z, 1 weak wait, 2 buffer, 3 disable wait, 4 low
  always @(posedge CLK) begin
    armed = 1'b1;
    cur = selc(m_s2);
    nst = m_st;
    ncnt = m_cnt;
    case (m_st)
      0: if (m_s2[2]) begin
        nst = 1;
        ncnt = 0;
      end
      // a wait aborts when the enable turns back, else ends on the second fall
      1, 3: if (m_s2[2] != (m_st == 1)) nst = (m_st == 1) ? 0 : 2;
        else if (m_prev && !cur) begin
          ncnt = m_cnt + 1;
          if (ncnt == 2) nst = m_st + 1;
        end
      2: if (!m_s2[2]) begin
        nst = 3;
        ncnt = 0;
      end
      default: if (!m_prev && cur) nst = 0;
    endcase
    if (!RST_N) nst = 0;
    m_out <= RST_N && (nst == 2 || nst == 3) && cur;
    m_oen <= !(RST_N && nst >= 2);
    m_weak <= RST_N && nst == 1;
    m_xtal <= RST_N && m_s2[1];
    m_drv <= RST_N && m_s2[1] && !m_s2[7];
    m_s1 <= RST_N ? pins : 8'h00;
    m_s2 <= RST_N ? m_s1 : 8'h00;
    m_prev <= RST_N && cur;
    m_st <= nst;
    m_cnt <= ncnt;
  end

  task automatic chk1(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk10(string n, logic [9:0] e, logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // outputs are settled at the falling edge
  always @(negedge CLK) begin
    if (armed) begin
      chk10("fanout_output", {10{m_out}}, fo);
      chk10("fanout_oe_n", {10{m_oen}}, fo_oen);
      chk10("weak_pulldown", {10{m_weak}}, fo_weak);
      chk1("xtal_power_on", m_xtal, xtal);
      chk1("osc_drive_pin", m_drv, drv);
    end
  end

  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // cuts a hang short after 100000 cycles
  initial begin
    #500000;
    err_total++;
    stop_test;
  end

  initial begin
    void'($urandom(87029));
    cyc(4);
    RST_N <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      {sel_hi, sel_lo, oe} <= {c[1:0], 1'b1};
      cyc(40);
      oe <= 1'b0;
      cyc(30);
    end
    $display("test select_codes done");
    // freeze each source while buffering, at every static pattern
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 4; p++) begin
        {sel_hi, sel_lo, oe} <= {k[1:0], 1'b1};
        run <= 3'h7;
        cyc(24);
        still <= {p[0], p[1:0], p[1:0]};
        run <= 3'h0;
        cyc(12);
      end
    end
    $display("test static_levels done");
    // enable with every source stopped must settle, not oscillate
    {run, oe} <= {3'h7, 1'b0};
    cyc(30);
    {run, still} <= 8'h00;
    cyc(8);
    oe <= 1'b1;
    cyc(30);
    $display("test enable_no_clock done");
    repeat (300) begin
      {sel_hi, sel_lo, oe} <= 3'($urandom);
      {run, still} <= 8'($urandom);
      half <= 4'($urandom_range(4, 1));
      cyc(int'($urandom_range(12, 1)));
    end
    RST_N <= 1'b0;
    cyc(4);
    RST_N <= 1'b1;
    cyc(20);
    $display("test random_and_reset done");
    stop_test;
  end
endmodule
